//--- hdl/cdb_pkg.sv
// Contract
// - CAN fault handling is enabled only while power-off config bit 7 is one.
// - In power latch mode a key rise makes a reset when bit 6 is set.
// - Power-off config bit 5 low enables power latch and safe engine off; default disabled.
// - Key off, latch disabled: bit 4 low drops supplies and relay, high only relay.
// - Bit 3 set masks 5 V undervoltage so stages are not switched off.
// - Bit 2 set makes 5 V undervoltage force the enabled upstream output low.
// - Bit 1 selects watchdog time base: one gives 1/64 kHz, zero 1/39 kHz.
// - Bit 0 gives safe-off priority over latch timer; then bits 4, 5 have no effect; here bit 5 still drives safe_engine_off_en.
// - Bits 5 and 0 choose the power-off source from the four-row table.
// - Coil config bit 7 selects latch or no-latch short-to-supply diagnosis.
// - Coil config bit 6 selects current or voltage short-to-ground diagnosis.
// - Coil config bit 5 doubles diagnosis mask time for stages 13 to 28.
// - Coil config bits 3..0 enable low battery for stages 25, 21, 14, 13.
// - Low battery on stage 21 or 25 forces stages 21 to 28 independent.
// - Bridge config resets to 0x01, own command; bit 0 one means two bridges.
// - Two-bit fault codes: 00 ground, 01 open, 10 supply, 11 no fault.
// - Stage 9-14 register bit 3 shows live watchdog answer pin; bit 2 unused.
// - Stage 19-20 register bits 7 to 4 always read one.
// - Every diagnostic bit clears when its register is read.
// - Single mode stages 21 and 23 swap codes: 00 supply, 10 ground.
// - Bridge mode groups hold eight-bit bridge codes from the fixed set.
// - While the lock bit is one all configuration writes are refused.
package cdb_pkg;

   // ********
   // Register map
   // ********
   localparam logic [3:0] ADDR_STAGE1_4      = 4'h1;
   localparam logic [3:0] ADDR_STAGE19_20    = 4'h2;
   localparam logic [3:0] ADDR_POWER_OFF_CFG = 4'h4;
   localparam logic [3:0] ADDR_STAGE5_8      = 4'h5;
   localparam logic [3:0] ADDR_GROUP21_24    = 4'h6;
   localparam logic [3:0] ADDR_COIL_LB_CFG   = 4'h8;
   localparam logic [3:0] ADDR_STAGE9_14     = 4'h9;
   localparam logic [3:0] ADDR_GROUP25_28    = 4'hA;
   localparam logic [3:0] ADDR_STAGE15_18    = 4'hD;

   localparam int unsigned NUM_DIAG = 7;
   localparam int unsigned DG_STAGE1_4   = 0;
   localparam int unsigned DG_STAGE5_8   = 1;
   localparam int unsigned DG_STAGE9_14  = 2;
   localparam int unsigned DG_STAGE15_18 = 3;
   localparam int unsigned DG_STAGE19_20 = 4;
   localparam int unsigned DG_GROUP21_24 = 5;
   localparam int unsigned DG_GROUP25_28 = 6;
   localparam logic [6:0][3:0] DIAG_ADDR = {ADDR_GROUP25_28, ADDR_GROUP21_24,
      ADDR_STAGE19_20, ADDR_STAGE15_18, ADDR_STAGE9_14, ADDR_STAGE5_8, ADDR_STAGE1_4};

   localparam logic [7:0] RST_POWER_OFF_CFG = 8'h22;
   localparam logic [7:0] RST_COIL_LB_CFG   = 8'h50;
   localparam logic [7:0] RST_BRIDGE_CFG    = 8'h01;
   localparam logic [7:0] COIL_LB_WR_MASK   = 8'hEF;
   localparam logic [7:0] UNMAPPED_READ     = 8'h00;

   // ********
   // Field positions
   // ********
   localparam int unsigned POC_CAN_EN     = 7;
   localparam int unsigned POC_KEYON_RST  = 6;
   localparam int unsigned POC_LATCH_DIS  = 5;
   localparam int unsigned POC_KEEP_ON    = 4;
   localparam int unsigned POC_UV_MASK    = 3;
   localparam int unsigned POC_UV_LOW_OUT = 2;
   localparam int unsigned POC_WD_BASE    = 1;
   localparam int unsigned POC_SEO_PRIO   = 0;
   localparam int unsigned CLC_LATCH_MODE = 7;
   localparam int unsigned CLC_GND_CURR   = 6;
   localparam int unsigned CLC_MASK_X2    = 5;
   localparam int unsigned CLC_LB25       = 3;
   localparam int unsigned CLC_LB21       = 2;
   localparam int unsigned BRG_CFG_BIT    = 0;
   localparam int unsigned D3_ANSWER_BIT  = 3;

   // ********
   // Fault codes
   // ********
   localparam logic [1:0] FC_SHORT_GND    = 2'h0;
   localparam logic [1:0] FC_OPEN_LOAD    = 2'h1;
   localparam logic [1:0] FC_SHORT_SUPPLY = 2'h2;
   localparam logic [1:0] FC_NO_FAULT     = 2'h3;
   localparam logic [7:0] BC_GND_OFF      = 8'h01;
   localparam logic [7:0] BC_SUPPLY_OFF   = 8'h05;
   localparam logic [7:0] BC_OPEN_OFF     = 8'h04;
   localparam logic [7:0] BC_OPEN_ON      = 8'h02;
   localparam logic [7:0] BC_OVERCURR_ON  = 8'h03;
   localparam logic [7:0] BC_RUNNING_ON   = 8'h07;
   localparam logic [7:0] BC_NO_FAULT     = 8'hFF;

   // ********
   // Timing
   // ********
   localparam int unsigned CLK_FREQ_HZ = 100_000_000;
   localparam int unsigned WD_FAST_HZ  = 64_000;
   localparam int unsigned WD_SLOW_HZ  = 39_000;
   localparam int unsigned WD_FAST_CYC = CLK_FREQ_HZ / WD_FAST_HZ;
   localparam int unsigned WD_SLOW_CYC = CLK_FREQ_HZ / WD_SLOW_HZ;

   // ********
   // Carriers
   // ********
   typedef struct packed {
      logic [7:0] stage1_4;
      logic [7:0] stage5_8;
      logic [7:0] stage9_14;
      logic [7:0] stage15_18;
      logic [7:0] stage19_20;
      logic [7:0] group21_24;
      logic [7:0] group25_28;
   } cdb_fault_src_t;

   typedef struct packed {
      logic       can_err_en;
      logic       keyon_latch_reset_en;
      logic       power_hold_en;
      logic       safe_engine_off_en;
      logic       wd_base_fast;
      logic       coil_diag_latch_mode;
      logic       coil_gnd_current_diag;
      logic       mask_time_double;
      logic [3:0] lowbatt_en;
      logic       bridge_mode;
   } cdb_ctrl_t;

   typedef struct packed {
      logic power_off;
      logic supply_off;
      logic main_relay_off;
      logic stages_off_uv;
      logic keyon_reset;
   } cdb_power_t;

endpackage

//--- hdl/cdb_diag_capture.sv
`timescale 1ns/10ps
module cdb_diag_capture
   import cdb_pkg::*;
#(
   parameter int unsigned FIELD_W = 2
)
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       reset,
   // Control
   input  wire logic       wide_mode,
   input  wire logic       clear_on_read,
   input  wire logic [7:0] fault_in,
   // Captured value
   output logic      [7:0] value_r
);

   localparam int unsigned NFIELD = 8 / FIELD_W;

   generate
      if ((FIELD_W == 0) || ((8 % FIELD_W) != 0))
      begin : g_bad_width
         $error("cdb_diag_capture: FIELD_W must divide 8");
      end
   endgenerate

   // ********
   // Capture with set over clear
   // ********
   logic [7:0] narrow_nxt;
   logic [7:0] wide_nxt;
   logic [7:0] value_nxt;

   genvar f;
   generate
      for (f = 0; f < NFIELD; f++)
      begin : g_field
         wire [FIELD_W-1:0] code = fault_in[f*FIELD_W +: FIELD_W];
         wire               hit  = (code != {FIELD_W{1'b1}});
         // A fault arriving in the read cycle is kept for the next read.
         assign narrow_nxt[f*FIELD_W +: FIELD_W] = hit ? code :
            clear_on_read ? {FIELD_W{1'b1}} : value_r[f*FIELD_W +: FIELD_W];
      end
   endgenerate

   assign wide_nxt  = (fault_in != BC_NO_FAULT) ? fault_in :
                      clear_on_read ? BC_NO_FAULT : value_r;
   assign value_nxt = wide_mode ? wide_nxt : narrow_nxt;

   always_ff @(posedge ref_clk)
   begin
      if (reset)
         value_r <= BC_NO_FAULT;
      else
         value_r <= value_nxt;
   end

endmodule // cdb_diag_capture

//--- hdl/cdb_config_diag_bank.sv
`timescale 1ns/10ps
module cdb_config_diag_bank
   import cdb_pkg::*;
#(
   parameter int unsigned WD_FAST_PERIOD = WD_FAST_CYC,
   parameter int unsigned WD_SLOW_PERIOD = WD_SLOW_CYC
)
(
   // Clock and reset
   input  wire logic           ref_clk,
   input  wire logic           reset,
   // Register command port
   input  wire logic           wr_en,
   input  wire logic [3:0]     wr_addr,
   input  wire logic [7:0]     wr_data,
   input  wire logic           cps_wr_en,
   input  wire logic [7:0]     cps_wr_data,
   input  wire logic           lock_cmd,
   input  wire logic           unlock_cmd,
   input  wire logic           rd_en,
   input  wire logic [3:0]     rd_addr,
   output logic      [7:0]     rd_data_r,
   output logic                rd_valid_r,
   output logic                lock_status_r,
   // Device status inputs
   input  wire logic           key_on,
   input  wire logic           wd_error,
   input  wire logic           latch_timer_expired,
   input  wire logic           main5v_undervolt,
   input  wire logic           watchdog_answer,
   input  wire logic           can_fault_raw,
   input  wire cdb_fault_src_t fault_src,
   // Upstream serial data path
   input  wire logic           upstream_data_raw,
   input  wire logic           upstream_oe,
   output logic                upstream_data_out_r,
   // Control outputs
   output cdb_ctrl_t           ctrl,
   output cdb_power_t          power_r,
   output logic                can_fault_out_r,
   output logic                wd_base_tick_r
);

   // ********
   // Elaboration checks
   // ********

   generate
      if ((WD_FAST_PERIOD < 2) ||
          (WD_FAST_PERIOD > 65535) ||
          (WD_SLOW_PERIOD < 2) ||
          (WD_SLOW_PERIOD > 65535))
      begin : g_bad_period
         $error("cdb_config_diag_bank: watchdog periods must lie in 2..65535");
      end
   endgenerate

   localparam logic [15:0] FAST_LAST = 16'(WD_FAST_PERIOD - 1);
   localparam logic [15:0] SLOW_LAST = 16'(WD_SLOW_PERIOD - 1);

   // ********
   // Registers
   // ********

   logic [7:0]  poc_r;
   logic [7:0]  clc_r;
   logic [7:0]  brg_r;
   logic        key_prev_r;
   logic [15:0] wd_cnt_r;

   logic        lock_nxt;
   logic [7:0]  poc_nxt;
   logic [7:0]  clc_nxt;
   logic [7:0]  brg_nxt;
   logic [15:0] wd_cnt_nxt;
   cdb_power_t  power_nxt;

   // ********
   // Write decode and lock
   // ********

   // Lock wins over unlock when both arrive together, so a racing pair
   // never leaves the configuration writable by surprise.
   assign lock_nxt = lock_cmd   ? 1'b1 :
                     unlock_cmd ? 1'b0 :
                                  lock_status_r;

   wire wr_ok      = wr_en & ~lock_status_r;
   wire wr_poc     = wr_ok & (wr_addr == ADDR_POWER_OFF_CFG);
   wire wr_clc     = wr_ok & (wr_addr == ADDR_COIL_LB_CFG);
   wire wr_brg     = cps_wr_en & ~lock_status_r;

   assign poc_nxt  = wr_poc ? wr_data : poc_r;
   assign clc_nxt  = wr_clc ? (wr_data & COIL_LB_WR_MASK) :
                              clc_r;
   assign brg_nxt  = wr_brg ? cps_wr_data : brg_r;

   // ********
   // Decoded configuration
   // ********

   wire latch_dis  = poc_r[POC_LATCH_DIS];
   wire seo_prio   = poc_r[POC_SEO_PRIO];
   wire keep_on    = poc_r[POC_KEEP_ON];
   wire direct_off = latch_dis & ~seo_prio;
   wire hold_mode  = ~latch_dis & ~seo_prio;
   wire lb21       = clc_r[CLC_LB21];
   wire lb25       = clc_r[CLC_LB25];

   wire bridge_on  = brg_r[BRG_CFG_BIT] &
                     ~(lb21 | lb25);

   assign ctrl.can_err_en            = poc_r[POC_CAN_EN];
   assign ctrl.keyon_latch_reset_en  = poc_r[POC_KEYON_RST];
   assign ctrl.power_hold_en         = hold_mode;
   assign ctrl.safe_engine_off_en    = ~latch_dis;
   assign ctrl.wd_base_fast          = poc_r[POC_WD_BASE];

   assign ctrl.coil_diag_latch_mode  = clc_r[CLC_LATCH_MODE];
   assign ctrl.coil_gnd_current_diag = clc_r[CLC_GND_CURR];
   assign ctrl.mask_time_double      = clc_r[CLC_MASK_X2];
   assign ctrl.lowbatt_en            = clc_r[3:0];
   assign ctrl.bridge_mode           = bridge_on;

   // ********
   // Power-off policy
   // ********

   // With the safe-off priority bit set, the latch enable and the supply
   // hold bit are ignored and only a watchdog error switches off.
   // The key level of the last cycle gives the rising edge for the reset.
   wire key_rise   = key_on & ~key_prev_r;
   wire timer_off  = hold_mode & ~key_on &
                     latch_timer_expired;
   wire off_event  = direct_off ? ~key_on :
                                  (wd_error | timer_off);

   assign power_nxt.power_off      = off_event;
   assign power_nxt.main_relay_off = off_event;
   assign power_nxt.supply_off     = direct_off ? (~key_on & ~keep_on) :
                                                  off_event;
   assign power_nxt.stages_off_uv  = main5v_undervolt & ~poc_r[POC_UV_MASK];
   assign power_nxt.keyon_reset    = hold_mode & key_rise &
                                     poc_r[POC_KEYON_RST];

   // ********
   // Upstream output and CAN gate
   // ********

   // The forced low hides every read while undervoltage lasts, which is
   // why software normally leaves this option off.
   wire uv_force_low = poc_r[POC_UV_LOW_OUT] & main5v_undervolt &
                       upstream_oe;
   wire upstream_nxt = uv_force_low ? 1'b0 : upstream_data_raw;
   wire can_nxt      = can_fault_raw & poc_r[POC_CAN_EN];

   // ********
   // Watchdog time base
   // ********

   wire [15:0] wd_last = poc_r[POC_WD_BASE] ? FAST_LAST :
                                              SLOW_LAST;
   // A switch to the shorter base while above its end wraps at once
   // rather than running the counter round its full range.
   wire        wd_wrap = (wd_cnt_r >= wd_last);
   assign wd_cnt_nxt   = wd_wrap ? 16'h0000 :
                                   (wd_cnt_r + 16'h0001);

   // ********
   // Fault source conditioning
   // ********

   function automatic logic [1:0] swap_gnd_supply(input logic [1:0] code);
   begin
      swap_gnd_supply = {code[1] ^ ~code[0], code[0]};
   end
   endfunction

   function automatic logic [7:0] bridge_filter(input logic [7:0] code);
      case (code)
         BC_GND_OFF,
         BC_SUPPLY_OFF,
         BC_OPEN_OFF,
         BC_OPEN_ON,
         BC_OVERCURR_ON,
         BC_RUNNING_ON: bridge_filter = code;
         default:                       bridge_filter = BC_NO_FAULT;
      endcase
   endfunction

   // Sources present two-bit codes in the common encoding; only stages 21
   // and 23 are translated into their own register encoding.
   wire [7:0] g21_single = {fault_src.group21_24[7:6],
                            swap_gnd_supply(fault_src.group21_24[5:4]),
                            fault_src.group21_24[3:2],
                            swap_gnd_supply(fault_src.group21_24[1:0])};
   // Unused bridge codes are dropped so a read never shows a meaningless code.
   wire [7:0] g21_in     = bridge_on ? bridge_filter(fault_src.group21_24)
                                     : g21_single;
   wire [7:0] g25_in     = bridge_on ? bridge_filter(fault_src.group25_28)
                                     : fault_src.group25_28;

   logic [NUM_DIAG-1:0][7:0] diag_in;
   logic [NUM_DIAG-1:0][7:0] diag_val;
   logic [NUM_DIAG-1:0][7:0] diag_view;
   logic [NUM_DIAG-1:0]      diag_wide;
   logic [NUM_DIAG-1:0]      diag_hit;

   assign diag_in[DG_STAGE1_4]   = fault_src.stage1_4;
   assign diag_in[DG_STAGE5_8]   = fault_src.stage5_8;
   assign diag_in[DG_STAGE9_14]  = {fault_src.stage9_14[7:4], 2'h3,
                                    fault_src.stage9_14[1:0]};
   assign diag_in[DG_STAGE15_18] = fault_src.stage15_18;
   assign diag_in[DG_STAGE19_20] = {4'hF,
                                    fault_src.stage19_20[3:0]};
   assign diag_in[DG_GROUP21_24] = g21_in;
   assign diag_in[DG_GROUP25_28] = g25_in;

   assign diag_wide = {bridge_on, bridge_on, 5'h00};

   // ********
   // Diagnostic capture registers
   // ********

   genvar d;
   generate
      for (d = 0; d < NUM_DIAG; d++)
      begin : g_diag
         // A read clears only the register that it addresses.
         assign diag_hit[d] = rd_en &
                              (rd_addr == DIAG_ADDR[d]);
         cdb_diag_capture #(
            .FIELD_W       (2)
         ) u_cap (
            .ref_clk       (ref_clk),
            .reset         (reset),
            .wide_mode     (diag_wide[d]),
            .clear_on_read (diag_hit[d]),
            .fault_in      (diag_in[d]),
            .value_r       (diag_val[d])
         );
      end
   endgenerate

   assign diag_view[DG_STAGE1_4]   = diag_val[DG_STAGE1_4];
   assign diag_view[DG_STAGE5_8]   = diag_val[DG_STAGE5_8];
   assign diag_view[DG_STAGE9_14]  = {diag_val[DG_STAGE9_14][7:4], watchdog_answer,
                                      1'b0, diag_val[DG_STAGE9_14][1:0]};
   assign diag_view[DG_STAGE15_18] = diag_val[DG_STAGE15_18];
   assign diag_view[DG_STAGE19_20] = {4'hF, diag_val[DG_STAGE19_20][3:0]};
   assign diag_view[DG_GROUP21_24] = diag_val[DG_GROUP21_24];
   assign diag_view[DG_GROUP25_28] = diag_val[DG_GROUP25_28];

   // ********
   // Read selection
   // ********

   logic [NUM_DIAG:0][7:0] diag_acc;

   assign diag_acc[0] = 8'h00;
   generate
      for (d = 0; d < NUM_DIAG; d++)
      begin : g_rdsel
         assign diag_acc[d+1] = diag_acc[d] |
                                (diag_hit[d] ? diag_view[d] : 8'h00);
      end
   endgenerate

   wire       any_diag = |diag_hit;
   wire [7:0] rd_mux   = (rd_addr == ADDR_POWER_OFF_CFG) ? poc_r :
                         (rd_addr == ADDR_COIL_LB_CFG)   ? clc_r :
                         any_diag                        ? diag_acc[NUM_DIAG] :
                                                           UNMAPPED_READ;

   // ********
   // Configuration and lock state
   // ********

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         poc_r         <= RST_POWER_OFF_CFG;
         clc_r         <= RST_COIL_LB_CFG;
         brg_r         <= RST_BRIDGE_CFG;
         lock_status_r <= 1'b0;
      end
      else
      begin
         poc_r         <= poc_nxt;
         clc_r         <= clc_nxt;
         brg_r         <= brg_nxt;
         lock_status_r <= lock_nxt;
      end
   end

   // ********
   // Read data
   // ********

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         rd_data_r  <= 8'h00;
         rd_valid_r <= 1'b0;
      end
      else
      begin
         rd_data_r  <= rd_en ? rd_mux : rd_data_r;
         rd_valid_r <= rd_en;
      end
   end

   // ********
   // Power, pin and time base outputs
   // ********

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         power_r             <= '0;
         key_prev_r          <= 1'b0;
         upstream_data_out_r <= 1'b1;
         can_fault_out_r     <= 1'b0;
         wd_cnt_r            <= 16'h0000;
         wd_base_tick_r      <= 1'b0;
      end
      else
      begin
         power_r             <= power_nxt;
         key_prev_r          <= key_on;
         upstream_data_out_r <= upstream_nxt;
         can_fault_out_r     <= can_nxt;
         wd_cnt_r            <= wd_cnt_nxt;
         wd_base_tick_r      <= wd_wrap;
      end
   end

endmodule // cdb_config_diag_bank

//--- verif/cdb_config_diag_bank_sva.sv
`timescale 1ns/10ps
module cdb_config_diag_bank_sva
   import cdb_pkg::*;
#(
   parameter int unsigned WD_FAST_PERIOD = WD_FAST_CYC
)
(
   // Clock and reset
   input wire logic       ref_clk,
   input wire logic       reset,
   // Watched ports
   input wire logic [3:0] rd_addr,
   input wire logic [7:0] rd_data_r,
   input wire logic       rd_valid_r,
   input wire logic       lock_status_r,
   input wire logic       key_on,
   input wire logic       wd_error,
   input wire logic       latch_timer_expired,
   input wire logic       main5v_undervolt,
   input wire logic       watchdog_answer,
   input wire logic       can_fault_raw,
   input wire logic       upstream_data_raw,
   input wire logic       upstream_data_out_r,
   input wire cdb_ctrl_t  ctrl,
   input wire cdb_power_t power_r,
   input wire logic       can_fault_out_r,
   input wire logic       wd_base_tick_r
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   // ********
   // Time base gap counter
   // ********
   // Armed only after a tick seen in fast mode, since a base switch restarts the phase.
   logic [15:0] gap_r;
   logic        armed_r;
   always_ff @(posedge ref_clk)
   begin
      gap_r   <= (reset || wd_base_tick_r) ? 16'h0 : gap_r + 16'h1;
      armed_r <= (reset || !ctrl.wd_base_fast) ? 1'b0 : (armed_r || wd_base_tick_r);
   end
   property p_can; !$past(reset) |-> can_fault_out_r == $past(can_fault_raw && ctrl.can_err_en);
   endproperty
   a_can: assert property (p_can) else $error("CAN fault gate wrong");
   property p_krst; power_r.keyon_reset |->
      $past(key_on && ctrl.keyon_latch_reset_en && ctrl.power_hold_en); endproperty
   a_krst: assert property (p_krst) else $error("Key-on reset without cause");
   property p_tick; armed_r && ctrl.wd_base_fast |->
      wd_base_tick_r == (gap_r == 16'(WD_FAST_PERIOD - 1)); endproperty
   a_tick: assert property (p_tick) else $error("Fast time base period wrong");
   property p_off; !$past(reset) && $past(ctrl.power_hold_en) |->
      power_r.power_off == $past(wd_error || (latch_timer_expired && !key_on)); endproperty
   a_off: assert property (p_off) else $error("Latch row power-off wrong");
   property p_brg; ctrl.lowbatt_en[3] || ctrl.lowbatt_en[2] |-> !ctrl.bridge_mode; endproperty
   a_brg: assert property (p_brg) else $error("Bridge mode despite low battery");
   property p_ans; rd_valid_r && $past(rd_addr) == ADDR_STAGE9_14 |->
      rd_data_r[3:2] == {$past(watchdog_answer), 1'b0}; endproperty
   a_ans: assert property (p_ans) else $error("Answer pin bit wrong");
   property p_hi; rd_valid_r && $past(rd_addr) == ADDR_STAGE19_20 |-> rd_data_r[7:4] == 4'hF;
   endproperty
   a_hi: assert property (p_hi) else $error("Upper bits not ones");
   property p_lock; lock_status_r |=> $stable(ctrl); endproperty
   a_lock: assert property (p_lock) else $error("Config changed while locked");
   property p_sdo; !$past(reset) && !$past(main5v_undervolt) |->
      upstream_data_out_r == $past(upstream_data_raw); endproperty
   a_sdo: assert property (p_sdo) else $error("Upstream data not passed");
endmodule // cdb_config_diag_bank_sva
bind cdb_config_diag_bank cdb_config_diag_bank_sva #(.WD_FAST_PERIOD(WD_FAST_PERIOD))
   cdb_config_diag_bank_sva_i (.*);

//--- verif/cdb_host_model.sv
`timescale 1ns/10ps
module cdb_host_model
(
   // Clock and read answer
   input  wire logic       ref_clk,
   input  wire logic [7:0] rd_data_r,
   input  wire logic       rd_valid_r,
   // Command port
   output logic            wr_en       = 1'b0,
   output logic      [3:0] wr_addr     = 4'h0,
   output logic      [7:0] wr_data     = 8'h00,
   output logic            cps_wr_en   = 1'b0,
   output logic      [7:0] cps_wr_data = 8'h00,
   output logic            lock_cmd    = 1'b0,
   output logic            unlock_cmd  = 1'b0,
   output logic            rd_en       = 1'b0,
   output logic      [3:0] rd_addr     = 4'h0
);
   // ********
   // Controller commands
   // ********
   // Released data fields and the read address show the inverse, so stale values never look valid.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      wr_en   <= 1'b1;
      wr_addr <= a;
      wr_data <= d;
      @(posedge ref_clk);
      wr_en   <= 1'b0;
      wr_data <= ~d;
      #1;
   endtask
   // Kind 0 writes the bridge config, 1 locks, 2 unlocks.
   task automatic cmd(input int k, input logic [7:0] d);
      @(posedge ref_clk);
      cps_wr_en   <= (k == 0);
      cps_wr_data <= d;
      lock_cmd    <= (k == 1);
      unlock_cmd  <= (k == 2);
      @(posedge ref_clk);
      {cps_wr_en, lock_cmd, unlock_cmd} <= 3'h0;
      cps_wr_data <= ~d;
      #1;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      rd_en   <= 1'b1;
      rd_addr <= a;
      @(posedge ref_clk);
      rd_en   <= 1'b0;
      rd_addr <= ~a;
      #1;
      d = (rd_valid_r === 1'b1) ? rd_data_r : 8'hXX;
   endtask
endmodule // cdb_host_model

//--- verif/cdb_config_diag_bank_tb.sv
`timescale 1ns/10ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin num_errors++; \
   $display("Error at %0t: got %h, expected %h", $time, a, e); end end
module cdb_config_diag_bank_tb
   import cdb_pkg::*;
;
   logic           ref_clk = 1'b0;
   logic           reset = 1'b1;
   logic           wr_en, cps_wr_en, lock_cmd, unlock_cmd, rd_en, rd_valid_r, lock_status_r;
   logic     [3:0] wr_addr, rd_addr;
   logic     [7:0] wr_data, cps_wr_data, rd_data_r, d, g;
   logic           key_on = 0, wd_error = 0, latch_timer_expired = 0, main5v_undervolt = 0;
   logic           watchdog_answer = 0, can_fault_raw = 0, upstream_data_raw = 1, upstream_oe = 0;
   logic           upstream_data_out_r, can_fault_out_r, wd_base_tick_r;
   cdb_fault_src_t fault_src = '1;
   cdb_ctrl_t      ctrl;
   cdb_power_t     power_r;
   int             num_errors = 0, comparisons = 0, cyc = 0;
   cdb_config_diag_bank #(.WD_FAST_PERIOD(8), .WD_SLOW_PERIOD(13)) cdb_config_diag_bank_i (.*);
   cdb_host_model host_i (.*);
   // ********
   // Scenarios
   // ********
   task automatic go(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic ev(input int i, input logic [7:0] v, input logic [3:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      fault_src[8*(6-i) +: 8] <= v;
      @(posedge ref_clk);
      fault_src <= '1;
      host_i.rd(a, d); `CHK(d, e)
      host_i.rd(a, d); `CHK(d, e | (a == ADDR_STAGE9_14 ? 8'hF3 : 8'hFF))
   endtask
   task automatic t_diag();
      host_i.rd(ADDR_POWER_OFF_CFG, d); `CHK(d, 8'h22)
      host_i.rd(ADDR_COIL_LB_CFG, d); `CHK(d, 8'h50)
      host_i.rd(4'h0, d); `CHK(d, 8'h00)
      for (int c = 0; c < 3; c++) ev(DG_STAGE1_4, {6'h3F, 2'(c)}, ADDR_STAGE1_4, {6'h3F, 2'(c)});
      ev(DG_STAGE19_20, 8'h0E, ADDR_STAGE19_20, 8'hFE);
      watchdog_answer <= 1'b1;
      ev(DG_STAGE9_14, 8'h7F, ADDR_STAGE9_14, 8'h7B);
      watchdog_answer <= 1'b0;
   endtask
   task automatic t_cfg();
      host_i.wr(ADDR_COIL_LB_CFG, 8'hFF);
      host_i.rd(ADDR_COIL_LB_CFG, d); `CHK(d, 8'hEF)
      `CHK(ctrl[7:1], 7'h7F)
      host_i.wr(ADDR_COIL_LB_CFG, 8'h04); `CHK(ctrl.bridge_mode, 1'b0)
      host_i.wr(ADDR_COIL_LB_CFG, 8'h00); `CHK(ctrl.bridge_mode, 1'b1)
      ev(DG_GROUP21_24, BC_OVERCURR_ON, ADDR_GROUP21_24, 8'h03);
      host_i.cmd(0, 8'h00); `CHK(ctrl.bridge_mode, 1'b0)
      ev(DG_GROUP21_24, 8'hFC, ADDR_GROUP21_24, 8'hFE);
   endtask
   task automatic t_lock();
      host_i.cmd(1, 8'h00); `CHK(lock_status_r, 1'b1)
      host_i.wr(ADDR_POWER_OFF_CFG, 8'h00);
      host_i.cmd(0, 8'h01); `CHK(ctrl.bridge_mode, 1'b0)
      host_i.rd(ADDR_POWER_OFF_CFG, d); `CHK(d, 8'h22)
      host_i.cmd(2, 8'h00); `CHK(lock_status_r, 1'b0)
   endtask
   task automatic t_power();
      logic [2:0] n;
      host_i.wr(ADDR_POWER_OFF_CFG, 8'h42);
      `CHK(ctrl[11:8], 4'hF)
      key_on <= 1'b1;
      n = 0;
      repeat (4)
      begin
         go(1);
         n += 3'(power_r.keyon_reset);
      end
      `CHK(n, 3'h1)
      key_on <= 1'b0;
      latch_timer_expired <= 1'b1;
      go(3); `CHK(power_r.power_off, 1'b1)
      latch_timer_expired <= 1'b0;
      host_i.wr(ADDR_POWER_OFF_CFG, 8'h20);
      go(2); `CHK({power_r.supply_off, power_r.main_relay_off}, 2'h3)
      host_i.wr(ADDR_POWER_OFF_CFG, 8'h30);
      go(2); `CHK({power_r.supply_off, power_r.main_relay_off}, 2'h1)
      host_i.wr(ADDR_POWER_OFF_CFG, 8'h31);
      go(2); `CHK(power_r.power_off, 1'b0)
      wd_error <= 1'b1;
      go(3); `CHK(power_r.power_off, 1'b1)
      wd_error <= 1'b0;
   endtask
   task automatic t_uv();
      main5v_undervolt <= 1'b1;
      host_i.wr(ADDR_POWER_OFF_CFG, 8'h08);
      go(2); `CHK(power_r.stages_off_uv, 1'b0)
      {upstream_oe, can_fault_raw} <= 2'h3;
      host_i.wr(ADDR_POWER_OFF_CFG, 8'h86);
      go(2); `CHK({power_r.stages_off_uv, upstream_data_out_r, can_fault_out_r}, 3'h5)
      for (int b = 0; b < 2; b++)
      begin
         host_i.wr(ADDR_POWER_OFF_CFG, b ? 8'h86 : 8'h84);
         for (int k = 0; k < 60 && wd_base_tick_r !== 1'b1; k++) go(1);
         g = 0;
         for (int k = 0; k < 60 && (g == 0 || wd_base_tick_r !== 1'b1); k++)
         begin
            go(1);
            g++;
         end
         `CHK(g, b ? 8'h08 : 8'h0D)
      end
   endtask
   task automatic final_report();
      $display("Comparisons %0d, errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         num_errors++;
         final_report();
      end
   end
   initial
   begin
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      t_diag();
      t_cfg();
      t_lock();
      t_power();
      t_uv();
      final_report();
   end
endmodule // cdb_config_diag_bank_tb
